//--- psm_pkg.sv
// constants and types shared by the peak signal monitor
package psm_pkg;
  // ==========================================================
  // register offsets
  localparam logic [11:0] PSM_ADDR_CTRL = 12'h270;
  localparam logic [11:0] PSM_ADDR_PERIOD0 = 12'h271;
  localparam logic [11:0] PSM_ADDR_PERIOD1 = 12'h272;
  localparam logic [11:0] PSM_ADDR_PERIOD2 = 12'h273;
  localparam logic [11:0] PSM_ADDR_UPDATE = 12'h274;
  localparam logic [11:0] PSM_ADDR_RESULT0 = 12'h275;
  localparam logic [11:0] PSM_ADDR_RESULT1 = 12'h276;
  localparam logic [11:0] PSM_ADDR_RESULT2 = 12'h277;
  localparam logic [11:0] PSM_ADDR_FCOUNT = 12'h278;
  localparam logic [11:0] PSM_ADDR_EMB_A = 12'h279;
  localparam logic [11:0] PSM_ADDR_EMB_B = 12'h27A;
  localparam logic [11:0] PSM_ADDR_LINK_A = 12'h559;
  localparam logic [11:0] PSM_ADDR_LINK_B = 12'h55A;
  localparam logic [11:0] PSM_ADDR_LINK_C = 12'h58F;
  // ==========================================================
  // field positions and widths
  localparam int PSM_PEAK_EN_BIT = 1;
  localparam int PSM_UPDATE_BIT = 4;
  localparam int PSM_EMB_B_BIT = 1;
  localparam logic [1:0] PSM_EMB_A_FIELD = 2'h3;
  localparam int PSM_SAMPLE_W = 14;
  localparam int PSM_PEAK_W = 13;
  localparam int PSM_PERIOD_W = 24;
  localparam int PSM_RESULT_W = 20;
  localparam int PSM_FRAME_W = 25;
  localparam int PSM_SUB_W = 5;
  localparam int PSM_SUB_N = 5;
  localparam int PSM_CS_W = 3;
  localparam logic [4:0] PSM_FRAME_LAST = 5'h18;
  localparam logic [1:0] PSM_FIFO_DEPTH = 2'h2;
  // ==========================================================
  // reset values and the magnitude saturation ceiling
  localparam logic [7:0] PSM_RST_BYTE = 8'h00;
  localparam logic [23:0] PSM_RST_PERIOD = 24'h000000;
  localparam logic [12:0] PSM_PEAK_SAT = 13'h1FFF;
  // ==========================================================
  // types
  typedef struct packed {
    logic [13:0] data;
    logic [2:0] ctrl;
  } psm_word_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [23:0] period;
    logic [7:0] emb_a;
    logic [7:0] emb_b;
    logic [7:0] link_a;
    logic [7:0] link_b;
    logic [7:0] link_c;
    logic en_d;
    logic [23:0] timer;
    logic seed;
    logic [12:0] stored;
    logic [12:0] hold;
    logic [7:0] xfer_cnt;
    logic [12:0] rd_result;
    logic [7:0] rd_fcount;
    logic frame_pend;
    logic [24:0] shift;
    logic [4:0] shift_cnt;
    psm_word_t [1:0] mem;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic [7:0] rdata;
  } psm_state_t;
endpackage : psm_pkg

//--- psm_monitor.sv
// peak magnitude signal monitor with register readback and control-bit embedding
`timescale 1ns/10ps
// ==========================================================
// Summary of operation
// R1: compare sample magnitudes, sign ignored
// R2: peak level is unsigned 13 bits
// R3: shared 24-bit period counted in samples
// R4: control bit 1 enables peak detection
// R5: host writes period before enabling
// R6: enable loads period into per-sample countdown
// R7: keep larger of sample and stored magnitude
// R8: each period seeds storage with current sample
// R9: at count 1 copy peak to holding
// R10: reload timer after transfer, next sample seeds
// R11: update bit write refreshes counter and result
// R12: host polls counter change before reading result
// R13: result is 20-bit word, peak MSB aligned
// R14: embedding needs two control register fields set
// R15: three control bits, monitor uses one
// R16: control bits fill from MSB downward
// R17: host programs three link option registers
// R18: 25-bit frame, MSB first, five subframes
// R19: every subframe opens with a start bit
// R20: receiver extracts and reassembles control bits
// R21: control bits per sample are 0 to 3
// R22: holding register keeps value until next expiry
module psm_monitor
  import psm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // decimated sample input
  input wire logic sample_valid,
  input wire logic [13:0] sample_data,
  output logic sample_ready,
  // sample output with control bits
  output logic out_valid,
  input wire logic out_ready,
  output psm_word_t out_word
);

  // ==========================================================
  // state and helpers
  psm_state_t st;
  psm_state_t next_st;
  logic accept;
  logic [13:0] abs_val;
  logic [12:0] mag;
  logic [12:0] cur_peak;
  logic peak_en;
  logic start;
  logic emb_on;
  logic expire;
  logic [19:0] result_word;
  logic [24:0] frame;
  logic [19:0] hold_word;

  // magnitude only, full-scale negative saturates to the 13-bit ceiling
  assign abs_val = sample_data[13] ? (~sample_data + 14'h0001) : sample_data; // [R1]
  assign mag = abs_val[13] ? PSM_PEAK_SAT : abs_val[12:0]; // [R2]
  assign cur_peak = (st.seed || mag > st.stored) ? mag : st.stored; // [R7] [R8]
  assign peak_en = st.ctrl[PSM_PEAK_EN_BIT]; // [R4]
  assign start = peak_en && !st.en_d;
  assign accept = sample_valid && sample_ready;
  assign expire = peak_en && !start && accept && (st.timer <= 24'h000001);
  // both embedding fields and a nonzero bit count are needed
  assign emb_on = (st.emb_a[1:0] == PSM_EMB_A_FIELD) && st.emb_b[PSM_EMB_B_BIT]
    && (st.link_a[1:0] != 2'h0); // [R14] [R21]
  assign result_word = {st.rd_result, 7'h00}; // [R13]
  // the frame carries the live holding value, not the readback snapshot
  assign hold_word = {st.hold, 7'h00}; // [R13]

  // frame build: each 5-bit subframe is a start bit and 4 result bits
  genvar k;
  generate
    for (k = 0; k < PSM_SUB_N; k++) begin : g_sub
      assign frame[PSM_FRAME_W-1-k*PSM_SUB_W] = 1'b1; // [R19]
      assign frame[PSM_FRAME_W-2-k*PSM_SUB_W -: 4] = hold_word[PSM_RESULT_W-1-k*4 -: 4]; // [R18]
    end
  endgenerate

  // handshake outputs straight from buffer occupancy
  assign sample_ready = (st.count != PSM_FIFO_DEPTH);
  assign out_valid = (st.count != 2'h0);
  assign out_word = st.mem[st.rd_ptr];
  assign reg_rdata = st.rdata;

  // ==========================================================
  // next-state logic
  always_comb begin
    logic ser_bit;
    logic push;
    logic pop;
    ser_bit = 1'b0;
    push = accept;
    pop = out_valid && out_ready;
    next_st = st;
    next_st.en_d = peak_en;

    // serial frame, one bit per accepted sample, idle sends zero
    if (accept) begin
      if (st.shift_cnt != 5'h00) begin
        ser_bit = st.shift[PSM_FRAME_W-1];
        next_st.shift = {st.shift[PSM_FRAME_W-2:0], 1'b0};
        next_st.shift_cnt = st.shift_cnt - 5'h01;
      end else if (st.frame_pend && emb_on) begin
        ser_bit = frame[PSM_FRAME_W-1]; // [R18]
        next_st.shift = {frame[PSM_FRAME_W-2:0], 1'b0};
        next_st.shift_cnt = PSM_FRAME_LAST;
        next_st.frame_pend = 1'b0;
      end
    end

    // peak tracking; a new transfer sets pending after any clear above
    if (start) begin
      next_st.timer = st.period; // [R6]
      next_st.seed = 1'b1;
    end else if (peak_en && accept) begin
      next_st.stored = cur_peak; // [R7]
      next_st.seed = 1'b0;
      if (expire) begin
        next_st.hold = cur_peak; // [R9] [R22]
        next_st.xfer_cnt = st.xfer_cnt + 8'h01;
        next_st.frame_pend = 1'b1;
        next_st.timer = st.period; // [R10]
        next_st.seed = 1'b1; // [R10]
      end else begin
        next_st.timer = st.timer - 24'h000001; // [R6] [R3]
      end
    end

    // two-entry buffer, MSB control position carries the frame
    if (push) begin
      next_st.mem[st.wr_ptr] = '{data: sample_data, ctrl: emb_on ? {ser_bit, 2'b00} : 3'b000}; // [R15] [R16]
      next_st.wr_ptr = ~st.wr_ptr;
    end
    if (pop) begin
      next_st.rd_ptr = ~st.rd_ptr;
    end
    next_st.count = st.count + {1'b0, push} - {1'b0, pop};

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        PSM_ADDR_CTRL: next_st.ctrl = reg_wdata;
        PSM_ADDR_PERIOD0: next_st.period[7:0] = reg_wdata; // [R3]
        PSM_ADDR_PERIOD1: next_st.period[15:8] = reg_wdata;
        PSM_ADDR_PERIOD2: next_st.period[23:16] = reg_wdata;
        PSM_ADDR_UPDATE: begin
          if (reg_wdata[PSM_UPDATE_BIT]) begin
            next_st.rd_result = st.hold; // [R11]
            next_st.rd_fcount = st.xfer_cnt; // [R11]
          end
        end
        PSM_ADDR_EMB_A: next_st.emb_a = reg_wdata;
        PSM_ADDR_EMB_B: next_st.emb_b = reg_wdata;
        PSM_ADDR_LINK_A: next_st.link_a = reg_wdata;
        PSM_ADDR_LINK_B: next_st.link_b = reg_wdata;
        PSM_ADDR_LINK_C: next_st.link_c = reg_wdata;
        default: ;
      endcase
    end

    // registered read data, unmapped and update offsets read zero
    if (reg_rd) begin
      unique case (reg_addr)
        PSM_ADDR_CTRL: next_st.rdata = st.ctrl;
        PSM_ADDR_PERIOD0: next_st.rdata = st.period[7:0];
        PSM_ADDR_PERIOD1: next_st.rdata = st.period[15:8];
        PSM_ADDR_PERIOD2: next_st.rdata = st.period[23:16];
        PSM_ADDR_RESULT0: next_st.rdata = result_word[7:0]; // [R13]
        PSM_ADDR_RESULT1: next_st.rdata = result_word[15:8];
        PSM_ADDR_RESULT2: next_st.rdata = {4'h0, result_word[19:16]};
        PSM_ADDR_FCOUNT: next_st.rdata = st.rd_fcount;
        PSM_ADDR_EMB_A: next_st.rdata = st.emb_a;
        PSM_ADDR_EMB_B: next_st.rdata = st.emb_b;
        PSM_ADDR_LINK_A: next_st.rdata = st.link_a;
        PSM_ADDR_LINK_B: next_st.rdata = st.link_b;
        PSM_ADDR_LINK_C: next_st.rdata = st.link_c;
        default: next_st.rdata = PSM_RST_BYTE;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.period <= PSM_RST_PERIOD;
      st.ctrl <= PSM_RST_BYTE;
      st.rdata <= PSM_RST_BYTE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // checks
  a_seed_sample: assert property (@(posedge mclk) disable iff (!resetn) // [R8]
    (peak_en && !start && accept && st.seed) |=> (st.stored == $past(mag)))
    else $error("storage not seeded by first sample");
  a_keep_larger: assert property (@(posedge mclk) disable iff (!resetn) // [R7]
    (peak_en && !start && accept && !st.seed) |=> (st.stored >= $past(st.stored) && st.stored >= $past(mag)))
    else $error("stored magnitude lost a larger value");
  a_timer_dec: assert property (@(posedge mclk) disable iff (!resetn) // [R6]
    (peak_en && !start && accept && st.timer > 24'h000001) |=> (st.timer == $past(st.timer) - 24'h000001))
    else $error("timer did not decrement");
  a_start_load: assert property (@(posedge mclk) disable iff (!resetn) // [R4]
    start |=> (st.timer == $past(st.period) && st.seed))
    else $error("enable did not load period");
  a_hold_xfer: assert property (@(posedge mclk) disable iff (!resetn) // [R9]
    expire |=> (st.hold == $past(cur_peak) && st.timer == $past(st.period) && st.seed && st.frame_pend))
    else $error("expiry transfer or reload wrong");
  a_hold_stable: assert property (@(posedge mclk) disable iff (!resetn) // [R22]
    !expire |=> $stable(st.hold))
    else $error("holding register changed without expiry");
  a_update_snap: assert property (@(posedge mclk) disable iff (!resetn) // [R11]
    (reg_wr && reg_addr == PSM_ADDR_UPDATE && reg_wdata[PSM_UPDATE_BIT])
      |=> (st.rd_result == $past(st.hold) && st.rd_fcount == $past(st.xfer_cnt)))
    else $error("update write did not refresh result");
  a_ctrl_msb: assert property (@(posedge mclk) disable iff (!resetn) // [R16]
    out_valid |-> (out_word.ctrl[1:0] == 2'b00))
    else $error("monitor bit outside top control position");
  a_frame_len: assert property (@(posedge mclk) disable iff (!resetn) // [R18]
    (accept && st.shift_cnt == 5'h00 && st.frame_pend && emb_on) |=> (st.shift_cnt == PSM_FRAME_LAST))
    else $error("frame length not 25 bits");
  a_buf_full: assert property (@(posedge mclk) disable iff (!resetn)
    (st.count == PSM_FIFO_DEPTH && !out_ready) |=> (st.count == PSM_FIFO_DEPTH && $stable(out_word) && !sample_ready))
    else $error("full buffer lost or took a word");

  // ==========================================================
  // checks on magnitude and enable
  // the magnitude checks do their own arithmetic, so a slip in the datapath
  // cannot hide behind an expression copied from it
  a_mag_pos: assert property (@(posedge mclk) disable iff (!resetn) // [R1]
    (sample_valid && !sample_data[13]) |-> (mag == sample_data[12:0]))
    else $error("positive sample magnitude wrong");
  a_mag_neg: assert property (@(posedge mclk) disable iff (!resetn) // [R1]
    (sample_valid && sample_data[13] && sample_data[12:0] != 13'h0000) |-> (mag == 13'(14'h0000 - sample_data)))
    else $error("negative sample magnitude wrong");
  a_mag_sat: assert property (@(posedge mclk) disable iff (!resetn) // [R2]
    (sample_valid && sample_data == 14'h2000) |-> (mag == PSM_PEAK_SAT))
    else $error("full scale negative did not saturate");
  a_idle_off: assert property (@(posedge mclk) disable iff (!resetn) // [R4]
    !peak_en |=> ($stable(st.stored) && $stable(st.hold)))
    else $error("monitor moved while disabled");
  a_start_skip: assert property (@(posedge mclk) disable iff (!resetn) // [R6]
    start |=> $stable(st.stored))
    else $error("enable cycle sample was monitored");
  a_xfer_count: assert property (@(posedge mclk) disable iff (!resetn) // [R9]
    expire |=> (st.xfer_cnt == $past(st.xfer_cnt) + 8'h01))
    else $error("transfer not counted");
  a_period_byte: assert property (@(posedge mclk) disable iff (!resetn) // [R3]
    (reg_wr && reg_addr == PSM_ADDR_PERIOD2) |=> (st.period[23:16] == $past(reg_wdata)))
    else $error("period top byte not written");

  // ==========================================================
  // checks on register readback
  // reads see the snapshot, so a transfer between the update write
  // and the result reads cannot tear the three bytes apart
  a_fcount_read: assert property (@(posedge mclk) disable iff (!resetn) // [R11]
    (reg_rd && reg_addr == PSM_ADDR_FCOUNT) |=> (reg_rdata == $past(st.rd_fcount)))
    else $error("frame counter readback wrong");
  a_result_low: assert property (@(posedge mclk) disable iff (!resetn) // [R13]
    (reg_rd && reg_addr == PSM_ADDR_RESULT0) |=> (reg_rdata == {$past(st.rd_result[0]), 7'h00}))
    else $error("low result byte wrong");
  a_result_top: assert property (@(posedge mclk) disable iff (!resetn) // [R2] [R13]
    (reg_rd && reg_addr == PSM_ADDR_RESULT2) |=> (reg_rdata == {4'h0, $past(st.rd_result[12:9])}))
    else $error("top result byte wrong");
  a_update_zero: assert property (@(posedge mclk) disable iff (!resetn) // [R11]
    (reg_rd && reg_addr == PSM_ADDR_UPDATE) |=> (reg_rdata == 8'h00))
    else $error("update offset did not read zero");

  // ==========================================================
  // checks on the embedded stream
  // each slot is checked as it is pushed, since the buffer may hold it
  // for several cycles while the receiver stalls
  a_emb_off: assert property (@(posedge mclk) disable iff (!resetn) // [R14]
    (accept && !emb_on) |=> (st.mem[$past(st.wr_ptr)].ctrl == 3'b000))
    else $error("control bits set while embedding off");
  a_idle_zero: assert property (@(posedge mclk) disable iff (!resetn) // [R16]
    (accept && emb_on && st.shift_cnt == 5'h00 && !st.frame_pend) |=> (st.mem[$past(st.wr_ptr)].ctrl == 3'b000))
    else $error("idle slot carried a set bit");
  a_frame_start: assert property (@(posedge mclk) disable iff (!resetn) // [R19]
    (accept && st.shift_cnt == 5'h00 && st.frame_pend && emb_on) |=> (st.mem[$past(st.wr_ptr)].ctrl == 3'b100))
    else $error("frame did not open with a start bit");
  a_frame_bit: assert property (@(posedge mclk) disable iff (!resetn) // [R16] [R18]
    (accept && emb_on && st.shift_cnt != 5'h00)
      |=> (st.mem[$past(st.wr_ptr)].ctrl == {$past(st.shift[24]), 2'b00}))
    else $error("frame bit not carried in top control position");
  a_shift_step: assert property (@(posedge mclk) disable iff (!resetn) // [R18]
    (accept && st.shift_cnt != 5'h00) |=> (st.shift_cnt == $past(st.shift_cnt) - 5'h01))
    else $error("frame bit count did not step");
  a_push_data: assert property (@(posedge mclk) disable iff (!resetn) // [R15]
    accept |=> (st.mem[$past(st.wr_ptr)].data == $past(sample_data)))
    else $error("sample data altered in buffer");

endmodule : psm_monitor

//--- psm_rx_model.sv
// receiver-side model: drains sample words and rebuilds monitor frames
`timescale 1ns/10ps
module psm_rx_model
  import psm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // sample stream
  input wire logic out_valid,
  input wire psm_word_t out_word,
  output logic out_ready,
  // test control and results
  input wire logic stall,
  output logic [19:0] frame_data,
  output logic [7:0] nframes,
  output logic [7:0] bad
);
  logic [13:0] got[$];
  logic [24:0] sh;
  int n;
  // random pacing gives slow answers; ready moves off the sampling edge
  initial begin
    out_ready = 1'b0;
    forever @(negedge mclk) out_ready <= !stall && ($urandom_range(3) != 0);
  end
  // one control bit per word; a frame opens on the first set bit
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      n = 0;
      nframes <= 8'h00;
      bad <= 8'h00;
      frame_data <= 20'h00000;
    end else if (out_valid && out_ready) begin
      got.push_back(out_word.data);
      if (out_word.ctrl[1:0] !== 2'h0) bad <= bad + 8'h01;
      if (n > 0 || out_word.ctrl[2] === 1'b1) begin
        sh = {sh[23:0], out_word.ctrl[2]};
        n++;
      end
      if (n == 25) begin
        n = 0;
        if ({sh[24], sh[19], sh[14], sh[9], sh[4]} !== 5'h1F) bad <= bad + 8'h01;
        frame_data <= {sh[23:20], sh[18:15], sh[13:10], sh[8:5], sh[3:0]};
        nframes <= nframes + 8'h01;
      end
    end
  end
endmodule : psm_rx_model

//--- tb_peak_signal_monitor.sv
// self-checking bench for the peak signal monitor
`timescale 1ns/10ps
module tb_peak_signal_monitor;
  import psm_pkg::*;
  localparam int PERIOD = 30;
  logic mclk, resetn, reg_wr, reg_rd, sample_valid, stall, sample_ready, out_valid, out_ready;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd, nframes, bad;
  logic [13:0] sample_data;
  logic [13:0] sent[$];
  logic [12:0] pk;
  logic [12:0] peaks[$];
  logic [19:0] frame_data;
  psm_word_t out_word;
  int num_errors, n_checks, k;
  // ==========================================================
  // design and receiver
  psm_monitor psm_monitor_i (.mclk, .resetn, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .sample_valid, .sample_data, .sample_ready, .out_valid, .out_ready, .out_word);
  psm_rx_model psm_rx_model_i (.mclk, .resetn, .out_valid, .out_word, .out_ready, .stall,
    .frame_data, .nframes, .bad);
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #100us;
    num_errors++;
    end_of_test();
  end
  // ==========================================================
  // helpers
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    rd = reg_rdata;
  endtask : rdr
  // sign dropped; full negative scale saturates
  function automatic logic [12:0] mag(input logic [13:0] d);
    if (d == 14'h2000) return 13'h1FFF;
    return d[13] ? 13'(-d) : d[12:0];
  endfunction : mag
  // samples held until taken; expected peaks tracked per period
  task automatic send(input int n, input logic [13:0] corner);
    logic [13:0] d;
    for (int i = 0; i < n; i++) begin
      d = (i == 7) ? corner : 14'($urandom);
      @(negedge mclk);
      sample_valid = 1'b1;
      sample_data = d;
      while (sample_ready !== 1'b1) @(negedge mclk);
      sent.push_back(d);
      pk = (k == 0 || mag(d) > pk) ? mag(d) : pk;
      k++;
      if (k == PERIOD) begin
        peaks.push_back(pk);
        k = 0;
      end
    end
    @(negedge mclk);
    sample_valid = 1'b0;
  endtask : send
  // update-and-poll, then the three result bytes
  task automatic poll(input logic [7:0] cnt, input logic [12:0] p);
    // stale read data from a result byte must not end the poll early
    rd = ~cnt;
    for (int i = 0; i < 8 && rd !== cnt; i++) begin
      wr(PSM_ADDR_UPDATE, 8'h10);
      rdr(PSM_ADDR_FCOUNT);
    end
    chk(rd, cnt);
    rdr(PSM_ADDR_RESULT0);
    chk(rd, {p[0], 7'h00});
    rdr(PSM_ADDR_RESULT1);
    chk(rd, p[8:1]);
    rdr(PSM_ADDR_RESULT2);
    chk(rd, {4'h0, p[12:9]});
  endtask : poll
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(8));
    {resetn, reg_wr, reg_rd, sample_valid, stall, reg_addr, reg_wdata, sample_data, k} = '0;
    repeat (4) @(negedge mclk);
    chk(reg_rdata, 20'h0);
    chk(sample_ready, 20'h1);
    chk(out_valid, 20'h0);
    resetn = 1'b1;
    // embedding set up first so the first transfer is framed
    wr(PSM_ADDR_EMB_A, 8'h03);
    wr(PSM_ADDR_EMB_B, 8'h02);
    wr(PSM_ADDR_LINK_A, 8'h01);
    wr(PSM_ADDR_PERIOD0, 8'(PERIOD));
    wr(PSM_ADDR_PERIOD2, 8'h00);
    wr(PSM_ADDR_CTRL, 8'h02);
    rdr(PSM_ADDR_CTRL);
    chk(rd, 8'h02);
    rdr(PSM_ADDR_PERIOD0);
    chk(rd, 8'(PERIOD));
    rdr(12'h300);
    chk(rd, 8'h00);
    rdr(PSM_ADDR_UPDATE);
    chk(rd, 8'h00);
    repeat (3) @(negedge mclk);
    send(PERIOD, 14'h1555);
    poll(8'h01, peaks[0]);
    send(PERIOD, 14'h2000);
    repeat (20) @(negedge mclk);
    chk(frame_data, {peaks[0], 7'h00});
    chk(nframes, 8'h01);
    chk(bad, 8'h00);
    poll(8'h02, peaks[1]);
    poll(8'h02, peaks[1]);
    // receiver stalls: buffer fills to two and refuses
    @(posedge mclk) #1 stall = 1'b1;
    fork
      send(3, 14'h0000);
    join_none
    repeat (6) @(negedge mclk);
    chk(sample_ready, 20'h0);
    chk(out_valid, 20'h1);
    @(posedge mclk) #1 stall = 1'b0;
    repeat (30) @(negedge mclk);
    chk(psm_rx_model_i.got.size(), sent.size());
    foreach (sent[i]) chk(psm_rx_model_i.got[i], sent[i]);
    end_of_test();
  end
endmodule : tb_peak_signal_monitor
